// >>> calendar_clock_with_alarm.sv
`timescale 1ns/1ps
module calendar_clock_with_alarm (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  // Counting reference pin
  input  wire logic                      ref_clk_in,
  // Control
  input  wire logic                      clock_enable,
  input  wire logic                      leap_suppress,
  input  wire logic                      load_strobe,
  input  wire logic [rtc_pkg::DIV_W-1:0] second_divisor_minus_one,
  // Setup words
  input  wire logic [31:0]               setup_date_word,
  input  wire logic [31:0]               setup_tod_word,
  // Alarm setup
  input  wire logic                      alarm_global_enable,
  input  wire logic [31:0]               alarm_date_word,
  input  wire logic [31:0]               alarm_tod_word,
  input  wire logic                      irq_enable,
  input  wire logic                      irq_force,
  input  wire logic                      irq_clear,
  // Status
  output logic                           running,
  output logic                           load_busy,
  output logic                           match_active,
  // Time read
  input  wire logic                      tod_read,
  output logic [31:0]                    tod_word,
  output logic [31:0]                    date_word,
  // Alarm interrupt
  output logic                           irq_raw,
  output logic                           alarm_irq_cpu,
  output logic                           alarm_irq_osc
);
  import rtc_pkg::*;

  // Control crossing pipeline
  ctrl_t stage1_reg;
  ctrl_t stage1_next;
  ctrl_t stage2_reg;
  ctrl_t stage2_next;
  logic  load_pend_reg;
  logic  load_pend_next;
  logic  load1_reg;
  logic  load1_next;

  // Counters
  date_t date_reg;
  date_t date_next;
  tod_t  tod_reg;
  tod_t  tod_next;

  // Read side
  logic [31:0] date_latch_reg;
  logic [31:0] date_latch_next;

  // Alarm
  logic match_reg;
  logic match_next;
  logic raw_reg;
  logic raw_next;

  // Events
  logic ref_edge;
  logic sec_tick;
  logic load_now;
  logic advance;
  logic sec_roll;
  logic min_roll;
  logic hour_roll;
  logic day_roll;
  logic month_roll;
  logic leap_now;
  logic [DAY_W-1:0] month_len;

  // Alarm targets
  date_t alarm_date;
  tod_t  alarm_tod;
  logic  year_ena;
  logic  month_ena;
  logic  day_ena;
  logic  dotw_ena;
  logic  hour_ena;
  logic  min_ena;
  logic  sec_ena;
  logic  match_comb;

  function automatic logic [DAY_W-1:0] days_in_month(
    input logic [MONTH_W-1:0] month,
    input logic               leap
  );
    logic [DAY_W-1:0] n;
    case (month)
      MONTH_FEB: n = leap ? DAYS_29 : DAYS_28;
      4'h4, 4'h6, 4'h9, 4'hb: n = DAYS_30;
      default: n = DAYS_31;
    endcase
    return n;
  endfunction

  ref_tick_gen #(
    .DIV_W(DIV_W)
  ) u_tick (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .ref_clk_in       (ref_clk_in),
    .run              (stage2_reg.enable),
    .divisor_minus_one(stage2_reg.divisor),
    .ref_edge         (ref_edge),
    .sec_tick         (sec_tick)
  );

  // Control settles two reference edges after it is written. The divider
  // follows the pipeline too, so a change while running only shifts the
  // current second rather than corrupting the counter.
  always_comb begin
    stage1_next = stage1_reg;
    stage2_next = stage2_reg;
    load1_next = load1_reg;
    load_pend_next = load_pend_reg & ~ref_edge;
    if (load_strobe && !ref_edge) begin
      load_pend_next = 1'b1;
    end
    if (ref_edge) begin
      stage1_next.enable = clock_enable;
      stage1_next.leap_suppress = leap_suppress;
      stage1_next.divisor = second_divisor_minus_one;
      load1_next = load_pend_reg | load_strobe;
      stage2_next = stage1_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stage1_reg <= '{enable: 1'b0, leap_suppress: 1'b0, divisor: DIV_RESET};
      stage2_reg <= '{enable: 1'b0, leap_suppress: 1'b0, divisor: DIV_RESET};
      load_pend_reg <= 1'b0;
      load1_reg <= 1'b0;
    end else begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
      load_pend_reg <= load_pend_next;
      load1_reg <= load1_next;
    end
  end

  assign running = stage2_reg.enable;
  assign load_busy = load_pend_reg | load1_reg;

  // Calendar cascade
  always_comb begin
    load_now = ref_edge & load1_reg;
    advance = sec_tick & ~load_now;
    // Leap is only consulted here, at the ends of the February 28 and 29 days
    leap_now = (date_reg.year[1:0] == 2'b00) & ~stage2_reg.leap_suppress;
    month_len = days_in_month(date_reg.month, leap_now);
    // Equality limits only: out-of-range values run on until they wrap
    sec_roll = advance & (tod_reg.second == SEC_MAX);
    min_roll = sec_roll & (tod_reg.minute == MIN_MAX);
    hour_roll = min_roll & (tod_reg.hour == HOUR_MAX);
    day_roll = hour_roll;
    month_roll = day_roll & (date_reg.day == month_len);
    date_next = date_reg;
    tod_next = tod_reg;
    if (load_now) begin
      date_next = unpack_date(setup_date_word);
      tod_next = unpack_tod(setup_tod_word);
    end else if (advance) begin
      tod_next.second = sec_roll ? '0 : tod_reg.second + 1'b1;
      if (sec_roll) begin
        tod_next.minute = min_roll ? '0 : tod_reg.minute + 1'b1;
      end
      if (min_roll) begin
        tod_next.hour = hour_roll ? '0 : tod_reg.hour + 1'b1;
      end
      if (day_roll) begin
        // Sunday is 0; the weekday just steps, never from the date
        tod_next.dotw = (tod_reg.dotw == DOTW_SAT) ? '0
                        : tod_reg.dotw + 1'b1;
        date_next.day = month_roll ? DAY_FIRST : date_reg.day + 1'b1;
      end
      if (month_roll) begin
        if (date_reg.month == MONTH_MAX) begin
          date_next.month = 4'h1;
          date_next.year = date_reg.year + 1'b1;
        end else begin
          date_next.month = date_reg.month + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      date_reg <= '0;
      tod_reg <= '0;
    end else begin
      date_reg <= date_next;
      tod_reg <= tod_next;
    end
  end

  // Reading the time-of-day word freezes the date that goes with it
  always_comb begin
    date_latch_next = date_latch_reg;
    if (tod_read) begin
      date_latch_next = pack_date(date_reg);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      date_latch_reg <= 32'h0000_0000;
    end else begin
      date_latch_reg <= date_latch_next;
    end
  end

  assign tod_word = pack_tod(tod_reg);
  assign date_word = date_latch_reg;

  // Alarm compare
  always_comb begin
    alarm_date = unpack_date(alarm_date_word);
    alarm_tod = unpack_tod(alarm_tod_word);
    year_ena = alarm_date_word[ALM_YEAR_ENA_BIT];
    month_ena = alarm_date_word[ALM_MONTH_ENA_BIT];
    day_ena = alarm_date_word[ALM_DAY_ENA_BIT];
    dotw_ena = alarm_tod_word[ALM_DOTW_ENA_BIT];
    hour_ena = alarm_tod_word[ALM_HOUR_ENA_BIT];
    min_ena = alarm_tod_word[ALM_MIN_ENA_BIT];
    sec_ena = alarm_tod_word[ALM_SEC_ENA_BIT];
    match_comb = alarm_global_enable
      & (!year_ena  | (date_reg.year == alarm_date.year))
      & (!month_ena | (date_reg.month == alarm_date.month))
      & (!day_ena   | (date_reg.day == alarm_date.day))
      & (!dotw_ena  | (tod_reg.dotw == alarm_tod.dotw))
      & (!hour_ena  | (tod_reg.hour == alarm_tod.hour))
      & (!min_ena   | (tod_reg.minute == alarm_tod.minute))
      & (!sec_ena   | (tod_reg.second == alarm_tod.second));
    match_next = match_comb;
    // Only the start of a match sets the flag, so a clear sticks for the
    // rest of a matching second; a new match in the clear cycle still wins
    raw_next = (raw_reg & ~irq_clear) | (match_comb & ~match_reg);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      match_reg <= 1'b0;
      raw_reg <= 1'b0;
    end else begin
      match_reg <= match_next;
      raw_reg <= raw_next;
    end
  end

  assign match_active = match_reg;
  assign irq_raw = raw_reg;
  assign alarm_irq_cpu = (raw_reg & irq_enable) | irq_force;
  assign alarm_irq_osc = (raw_reg & irq_enable) | irq_force;

  a_load_copies: assert property (@(posedge clk) disable iff (sys_rst)
    ref_edge && load1_reg |=> date_reg == unpack_date($past(setup_date_word))
      && tod_reg == unpack_tod($past(setup_tod_word)))
    else $error("load did not copy setup");
  a_sec_step: assert property (@(posedge clk) disable iff (sys_rst)
    advance && tod_reg.second < SEC_MAX
      |=> tod_reg.second == $past(tod_reg.second) + 6'h01)
    else $error("second did not step");
  a_min_carry: assert property (@(posedge clk) disable iff (sys_rst)
    sec_roll && tod_reg.minute < MIN_MAX
      |=> tod_reg.second == '0
        && tod_reg.minute == $past(tod_reg.minute) + 6'h01)
    else $error("minute carry wrong");
  a_dotw_wrap: assert property (@(posedge clk) disable iff (sys_rst)
    day_roll && tod_reg.dotw == DOTW_SAT |=> tod_reg.dotw == 3'h0)
    else $error("weekday did not wrap");
  a_leap_day: assert property (@(posedge clk) disable iff (sys_rst)
    day_roll && date_reg.month == MONTH_FEB && date_reg.day == DAYS_28
      && date_reg.year[1:0] == 2'b00 && !stage2_reg.leap_suppress
      |=> date_reg.day == DAYS_29 && date_reg.month == MONTH_FEB)
    else $error("leap day skipped");
  a_leap_suppress: assert property (@(posedge clk) disable iff (sys_rst)
    day_roll && date_reg.month == MONTH_FEB && date_reg.day == DAYS_28
      && stage2_reg.leap_suppress
      |=> date_reg.day == DAY_FIRST && date_reg.month == 4'h3)
    else $error("leap not suppressed");
  a_run_on_edge: assert property (@(posedge clk) disable iff (sys_rst)
    running != $past(running) |-> $past(ref_edge)
      && $past(stage1_reg.enable) == running)
    else $error("running changed off edge");
  a_read_latch: assert property (@(posedge clk) disable iff (sys_rst)
    tod_read |=> date_word == pack_date($past(date_reg)))
    else $error("date not latched");
  a_global_gate: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(irq_raw) |-> $past(alarm_global_enable))
    else $error("alarm without global enable");
  a_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
    irq_clear && match_comb && !match_reg |=> irq_raw)
    else $error("clear beat new match");
  a_irq_routes: assert property (@(posedge clk) disable iff (sys_rst)
    irq_raw && irq_enable |-> alarm_irq_cpu && alarm_irq_osc)
    else $error("alarm not routed");

endmodule

// >>> rtc_pkg.sv
// Overview of operation
// - Widths: year 12, month 4, day 5, weekday 3, hour 5, min 6, sec 6.
// - No range checks on loaded values; illegal contents count unpredictably.
// - Weekday codes run Sunday 0 through Saturday 6.
// - Weekday only increments at each day rollover, wrapping after Saturday.
// - Year multiple of four, suppression clear: Feb 28 is followed by Feb 29.
// - Leap suppression bit set: Feb 28 is always followed by March 1.
// - Leap condition is sampled only at the Feb 28 and Feb 29 23:59:59 rollovers.
// - Alarm fires only while the global alarm enable is set.
// - Each field has its own match enable; disabled fields always match.
// - Alarm interrupt drives both processor and oscillator wake outputs.
// - Seconds tick divides the reference by programmed divisor plus one.
// - All control crosses between system and counting sides synchronised.
// - A write takes effect two reference periods after the system write.
// - Load pulse copies setup values into counters, even while running.
// - Time-of-day read latches the date word for a consistent following read.
// - Running follows enable after synchronisation, for stop-load-start.
// - Divisor-minus-one field is 16 bits wide, dividing by 1 to 65536.
// - Weekday, hour, minute, second match enables sit in bits 31 to 28.
package rtc_pkg;

  localparam int YEAR_W = 12;
  localparam int MONTH_W = 4;
  localparam int DAY_W = 5;
  localparam int DOTW_W = 3;
  localparam int HOUR_W = 5;
  localparam int MIN_W = 6;
  localparam int SEC_W = 6;
  localparam int DIV_W = 16;

  // Word layouts
  localparam int DATE_YEAR_LSB = 12;
  localparam int DATE_MONTH_LSB = 8;
  localparam int DATE_DAY_LSB = 0;
  localparam int TOD_DOTW_LSB = 24;
  localparam int TOD_HOUR_LSB = 16;
  localparam int TOD_MIN_LSB = 8;
  localparam int TOD_SEC_LSB = 0;
  localparam int ALM_DAY_ENA_BIT = 24;
  localparam int ALM_MONTH_ENA_BIT = 25;
  localparam int ALM_YEAR_ENA_BIT = 26;
  localparam int ALM_SEC_ENA_BIT = 28;
  localparam int ALM_MIN_ENA_BIT = 29;
  localparam int ALM_HOUR_ENA_BIT = 30;
  localparam int ALM_DOTW_ENA_BIT = 31;

  // Calendar limits
  localparam logic [SEC_W-1:0] SEC_MAX = 6'h3b;
  localparam logic [MIN_W-1:0] MIN_MAX = 6'h3b;
  localparam logic [HOUR_W-1:0] HOUR_MAX = 5'h17;
  localparam logic [DOTW_W-1:0] DOTW_SAT = 3'h6;
  localparam logic [MONTH_W-1:0] MONTH_MAX = 4'hc;
  localparam logic [MONTH_W-1:0] MONTH_FEB = 4'h2;
  localparam logic [DAY_W-1:0] DAY_FIRST = 5'h01;
  localparam logic [DAY_W-1:0] DAYS_28 = 5'h1c;
  localparam logic [DAY_W-1:0] DAYS_29 = 5'h1d;
  localparam logic [DAY_W-1:0] DAYS_30 = 5'h1e;
  localparam logic [DAY_W-1:0] DAYS_31 = 5'h1f;
  localparam logic [DIV_W-1:0] DIV_RESET = 16'h0000;

  typedef struct packed {
    logic [YEAR_W-1:0]  year;
    logic [MONTH_W-1:0] month;
    logic [DAY_W-1:0]   day;
  } date_t;

  typedef struct packed {
    logic [DOTW_W-1:0] dotw;
    logic [HOUR_W-1:0] hour;
    logic [MIN_W-1:0]  minute;
    logic [SEC_W-1:0]  second;
  } tod_t;

  typedef struct packed {
    logic             enable;
    logic             leap_suppress;
    logic [DIV_W-1:0] divisor;
  } ctrl_t;

  function automatic date_t unpack_date(input logic [31:0] w);
    date_t d;
    d.year = w[DATE_YEAR_LSB +: YEAR_W];
    d.month = w[DATE_MONTH_LSB +: MONTH_W];
    d.day = w[DATE_DAY_LSB +: DAY_W];
    return d;
  endfunction

  function automatic tod_t unpack_tod(input logic [31:0] w);
    tod_t t;
    t.dotw = w[TOD_DOTW_LSB +: DOTW_W];
    t.hour = w[TOD_HOUR_LSB +: HOUR_W];
    t.minute = w[TOD_MIN_LSB +: MIN_W];
    t.second = w[TOD_SEC_LSB +: SEC_W];
    return t;
  endfunction

  function automatic logic [31:0] pack_date(input date_t d);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[DATE_YEAR_LSB +: YEAR_W] = d.year;
    w[DATE_MONTH_LSB +: MONTH_W] = d.month;
    w[DATE_DAY_LSB +: DAY_W] = d.day;
    return w;
  endfunction

  function automatic logic [31:0] pack_tod(input tod_t t);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[TOD_DOTW_LSB +: DOTW_W] = t.dotw;
    w[TOD_HOUR_LSB +: HOUR_W] = t.hour;
    w[TOD_MIN_LSB +: MIN_W] = t.minute;
    w[TOD_SEC_LSB +: SEC_W] = t.second;
    return w;
  endfunction

endpackage

// >>> ref_tick_gen.sv
`timescale 1ns/1ps
module ref_tick_gen #(
  parameter int DIV_W = rtc_pkg::DIV_W
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Reference pin
  input  wire logic             ref_clk_in,
  // Divider control
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] divisor_minus_one,
  // Events
  output logic                  ref_edge,
  output logic                  sec_tick
);
  import rtc_pkg::*;

  logic [2:0]       sync_reg;
  logic [2:0]       sync_next;
  logic             level_reg;
  logic             level_next;
  logic [DIV_W-1:0] count_reg;
  logic [DIV_W-1:0] count_next;
  logic             stable;

  // A change counts only once the second and third stages agree
  always_comb begin
    sync_next = {sync_reg[1:0], ref_clk_in};
    stable = (sync_reg[1] == sync_reg[2]);
    level_next = stable ? sync_reg[2] : level_reg;
    ref_edge = stable & sync_reg[2] & ~level_reg;
    sec_tick = run & ref_edge & (count_reg == divisor_minus_one);
    count_next = count_reg;
    if (!run) begin
      count_next = '0;
    end else if (ref_edge) begin
      // Full 16-bit compare, so divisors 1 to 65536 all work
      if (count_reg == divisor_minus_one) begin
        count_next = '0;
      end else begin
        count_next = count_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_reg <= 3'h0;
      level_reg <= 1'b0;
      count_reg <= '0;
    end else begin
      sync_reg <= sync_next;
      level_reg <= level_next;
      count_reg <= count_next;
    end
  end

  // A stopped divider must restart from zero, so the first second is whole
  a_stop_clears: assert property (@(posedge clk) disable iff (sys_rst)
    !run |=> count_reg == '0) else $error("divider not cleared");
  a_div_restart: assert property (@(posedge clk) disable iff (sys_rst)
    sec_tick |=> count_reg == '0) else $error("divider not restarted");
  a_edge_spacing: assert property (@(posedge clk) disable iff (sys_rst)
    ref_edge |=> !ref_edge [*2]) else $error("edges too close");

endmodule

// >>> test_calendar_clock_with_alarm.sv
`timescale 1ns/1ps
module test_calendar_clock_with_alarm;
  import rtc_pkg::*;
  localparam int REF_PERIOD = 8;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        ref_clk_in = 1'b0;
  logic [2:0]  ref_cnt = 3'h0;
  logic        clock_enable = 1'b0;
  logic        leap_suppress = 1'b0;
  logic        load_strobe = 1'b0;
  logic [15:0] second_divisor_minus_one = 16'h0003;
  logic [31:0] setup_date_word = 32'h0000_0000;
  logic [31:0] setup_tod_word = 32'h0000_0000;
  logic        alarm_global_enable = 1'b0;
  logic [31:0] alarm_date_word = 32'h0000_0000;
  logic [31:0] alarm_tod_word = 32'h0000_0000;
  logic        irq_enable = 1'b0;
  logic        irq_force = 1'b0;
  logic        irq_clear = 1'b0;
  logic        tod_read = 1'b0;
  logic        running;
  logic        load_busy;
  logic        match_active;
  logic [31:0] tod_word;
  logic [31:0] date_word;
  logic        irq_raw;
  logic        alarm_irq_cpu;
  logic        alarm_irq_osc;
  int          n_errors = 0;
  int          comparisons = 0;

  calendar_clock_with_alarm uut (
    .clk(clk), .sys_rst(sys_rst), .ref_clk_in(ref_clk_in),
    .clock_enable(clock_enable), .leap_suppress(leap_suppress),
    .load_strobe(load_strobe),
    .second_divisor_minus_one(second_divisor_minus_one),
    .setup_date_word(setup_date_word), .setup_tod_word(setup_tod_word),
    .alarm_global_enable(alarm_global_enable),
    .alarm_date_word(alarm_date_word), .alarm_tod_word(alarm_tod_word),
    .irq_enable(irq_enable), .irq_force(irq_force), .irq_clear(irq_clear),
    .running(running), .load_busy(load_busy), .match_active(match_active),
    .tod_read(tod_read), .tod_word(tod_word), .date_word(date_word),
    .irq_raw(irq_raw), .alarm_irq_cpu(alarm_irq_cpu),
    .alarm_irq_osc(alarm_irq_osc)
  );

  always #12.5 clk = ~clk;

  // Reference pin runs free at eight system cycles a period
  always @(negedge clk) begin
    ref_cnt <= ref_cnt + 3'h1;
    ref_clk_in <= ref_cnt[2];
  end

  function automatic logic [31:0] mk_d(input logic [11:0] y,
                                       input logic [3:0] m,
                                       input logic [4:0] d);
    return {8'h00, y, m, 3'h0, d};
  endfunction

  function automatic logic [31:0] mk_t(input logic [2:0] w,
                                       input logic [4:0] h,
                                       input logic [5:0] mi,
                                       input logic [5:0] s);
    return {5'h00, w, 3'h0, h, 2'h0, mi, 2'h0, s};
  endfunction

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wait_run(input logic val);
    int n;
    n = 0;
    while (running !== val && n < 200) begin
      @(negedge clk);
      n++;
    end
    check("running", {31'h0, running}, {31'h0, val});
  endtask

  task automatic wait_change(input logic [31:0] old, output int n);
    n = 0;
    while (tod_word === old && n < 300) begin
      @(negedge clk);
      n++;
    end
    check("tick seen", {31'h0, n < 300}, 32'h1);
  endtask

  task automatic do_load();
    int n;
    load_strobe = 1'b1;
    @(negedge clk);
    load_strobe = 1'b0;
    check("load busy", {31'h0, load_busy}, 32'h1);
    n = 0;
    while (load_busy === 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    // Two reference periods, give or take the pin sampling
    check("load delay", {31'h0, n >= 6 && n <= 18}, 32'h1);
  endtask

  task automatic read_date(input logic [31:0] exp);
    tod_read = 1'b1;
    @(negedge clk);
    tod_read = 1'b0;
    @(negedge clk);
    check("date word", date_word, exp);
  endtask

  task automatic set_time(input logic [31:0] d, input logic [31:0] t);
    clock_enable = 1'b0;
    wait_run(1'b0);
    setup_date_word = d;
    setup_tod_word = t;
    do_load();
    check("tod after load", tod_word, t);
    read_date(d);
  endtask

  task automatic reset_case();
    check("reset tod", tod_word, 32'h0);
    check("reset date", date_word, 32'h0);
    check("reset flags", {26'h0, running, load_busy, match_active, irq_raw,
          alarm_irq_cpu, alarm_irq_osc}, 32'h0);
    $display("reset test done");
  endtask

  task automatic tick_case(input logic lp, input logic [31:0] d, t, ed, et);
    int n;
    leap_suppress = lp;
    set_time(d, t);
    second_divisor_minus_one = 16'h0003;
    clock_enable = 1'b1;
    wait_run(1'b1);
    wait_change(t, n);
    // Stop lands two edges later, well before the next tick
    clock_enable = 1'b0;
    check("tod after tick", tod_word, et);
    check("date held", date_word, d);
    read_date(ed);
    $display("tick test done");
  endtask

  task automatic div_case(input logic [15:0] d);
    logic [31:0] old;
    int n;
    set_time(mk_d(12'h7e7, 4'h3, 5'h0a), mk_t(3'h1, 5'h0a, 6'h14, 6'h1e));
    second_divisor_minus_one = d;
    clock_enable = 1'b1;
    wait_run(1'b1);
    wait_change(tod_word, n);
    old = tod_word;
    wait_change(old, n);
    check("tick period", n, ({16'h0, d} + 32'h1) * REF_PERIOD);
    setup_tod_word = mk_t(3'h2, 5'h05, 6'h06, 6'h07);
    do_load();
    check("load while running", tod_word, setup_tod_word);
    $display("divisor test done");
  endtask

  task automatic pulse_clear();
    irq_clear = 1'b1;
    @(negedge clk);
    irq_clear = 1'b0;
    @(negedge clk);
    check("raw cleared", {31'h0, irq_raw}, 32'h0);
  endtask

  task automatic alarm_case();
    int lsb[7] = '{DATE_DAY_LSB, DATE_MONTH_LSB, DATE_YEAR_LSB, TOD_SEC_LSB,
                   TOD_MIN_LSB, TOD_HOUR_LSB, TOD_DOTW_LSB};
    int ena[7] = '{ALM_DAY_ENA_BIT, ALM_MONTH_ENA_BIT, ALM_YEAR_ENA_BIT,
                   ALM_SEC_ENA_BIT, ALM_MIN_ENA_BIT, ALM_HOUR_ENA_BIT,
                   ALM_DOTW_ENA_BIT};
    logic [31:0] ad;
    logic [31:0] at;
    set_time(mk_d(12'h7e7, 4'h6, 5'h0f), mk_t(3'h4, 5'h0c, 6'h22, 6'h38));
    second_divisor_minus_one = 16'h0003;
    ad = setup_date_word | 32'h0700_0000;
    at = setup_tod_word | 32'hf000_0000;
    alarm_date_word = ad;
    alarm_tod_word = at;
    irq_enable = 1'b1;
    repeat (6) @(negedge clk);
    check("gated match", {31'h0, match_active}, 32'h0);
    check("gated raw", {31'h0, irq_raw}, 32'h0);
    alarm_global_enable = 1'b1;
    repeat (3) @(negedge clk);
    check("raw on match", {31'h0, irq_raw}, 32'h1);
    check("both irqs", {30'h0, alarm_irq_cpu, alarm_irq_osc}, 32'h3);
    irq_enable = 1'b0;
    @(negedge clk);
    check("masked", {30'h0, alarm_irq_cpu, alarm_irq_osc}, 32'h0);
    irq_force = 1'b1;
    @(negedge clk);
    check("forced", {30'h0, alarm_irq_cpu, alarm_irq_osc}, 32'h3);
    irq_force = 1'b0;
    irq_enable = 1'b1;
    pulse_clear();
    for (int i = 0; i < 7; i++) begin
      alarm_date_word = (i < 3) ? ad ^ (32'h1 << lsb[i]) : ad;
      alarm_tod_word = (i < 3) ? at : at ^ (32'h1 << lsb[i]);
      repeat (3) @(negedge clk);
      check("field mismatch", {31'h0, match_active}, 32'h0);
      if (i < 3) begin
        alarm_date_word[ena[i]] = 1'b0;
      end else begin
        alarm_tod_word[ena[i]] = 1'b0;
      end
      repeat (3) @(negedge clk);
      check("field ignored", {31'h0, match_active}, 32'h1);
      check("raw on new match", {31'h0, irq_raw}, 32'h1);
      pulse_clear();
    end
    // A match that starts in the clear cycle must still set the flag
    alarm_tod_word = at ^ 32'h1;
    repeat (2) @(negedge clk);
    irq_clear = 1'b1;
    alarm_tod_word = at;
    @(negedge clk);
    irq_clear = 1'b0;
    @(negedge clk);
    check("set beats clear", {31'h0, irq_raw}, 32'h1);
    alarm_global_enable = 1'b0;
    repeat (3) @(negedge clk);
    check("match off", {31'h0, match_active}, 32'h0);
    $display("alarm test done");
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    $display("BAD watchdog expired");
    give_verdict();
  end

  initial begin
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    reset_case();
    tick_case(1'b0, mk_d(12'h7e8, 4'h2, 5'h1c), mk_t(3'h6, 5'h17, 6'h3b,
      6'h3b), mk_d(12'h7e8, 4'h2, 5'h1d), mk_t(3'h0, 5'h00, 6'h00, 6'h00));
    tick_case(1'b1, mk_d(12'h7e8, 4'h2, 5'h1c), mk_t(3'h6, 5'h17, 6'h3b,
      6'h3b), mk_d(12'h7e8, 4'h3, 5'h01), mk_t(3'h0, 5'h00, 6'h00, 6'h00));
    tick_case(1'b0, mk_d(12'h7e7, 4'h2, 5'h1c), mk_t(3'h2, 5'h17, 6'h3b,
      6'h3b), mk_d(12'h7e7, 4'h3, 5'h01), mk_t(3'h3, 5'h00, 6'h00, 6'h00));
    tick_case(1'b0, mk_d(12'h7e8, 4'h2, 5'h1d), mk_t(3'h4, 5'h17, 6'h3b,
      6'h3b), mk_d(12'h7e8, 4'h3, 5'h01), mk_t(3'h5, 5'h00, 6'h00, 6'h00));
    tick_case(1'b0, mk_d(12'h7e7, 4'h4, 5'h1e), mk_t(3'h1, 5'h17, 6'h3b,
      6'h3b), mk_d(12'h7e7, 4'h5, 5'h01), mk_t(3'h2, 5'h00, 6'h00, 6'h00));
    tick_case(1'b0, mk_d(12'h7e7, 4'h1, 5'h1f), mk_t(3'h2, 5'h17, 6'h3b,
      6'h3b), mk_d(12'h7e7, 4'h2, 5'h01), mk_t(3'h3, 5'h00, 6'h00, 6'h00));
    tick_case(1'b0, mk_d(12'h7e7, 4'hc, 5'h1f), mk_t(3'h0, 5'h17, 6'h3b,
      6'h3b), mk_d(12'h7e8, 4'h1, 5'h01), mk_t(3'h1, 5'h00, 6'h00, 6'h00));
    tick_case(1'b0, mk_d(12'hfff, 4'hc, 5'h1f), mk_t(3'h3, 5'h17, 6'h3b,
      6'h3b), mk_d(12'h000, 4'h1, 5'h01), mk_t(3'h4, 5'h00, 6'h00, 6'h00));
    tick_case(1'b0, mk_d(12'h7e7, 4'h6, 5'h0f), mk_t(3'h4, 5'h0a, 6'h3b,
      6'h3b), mk_d(12'h7e7, 4'h6, 5'h0f), mk_t(3'h4, 5'h0b, 6'h00, 6'h00));
    div_case(16'h0000);
    div_case(16'h0002);
    div_case(16'h0005);
    alarm_case();
    give_verdict();
  end
endmodule
